/* hdl/ccc_map.svh */
// Register offsets, field positions, reset values and mode codes of the capture/compare unit
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

`define CCC_ADDR_W 12
`define CCC_OFS_CONTROL 12'h000
`define CCC_OFS_TIMER3 12'h004
`define CCC_OFS_CAP_LOW 12'h008
`define CCC_OFS_CAP_HIGH 12'h00C
`define CCC_OFS_STATUS 12'h010

`define CCC_CFG_HI 7
`define CCC_CFG_LO 6
`define CCC_DUTY_HI 5
`define CCC_DUTY_LO 4
`define CCC_MODE_HI 3
`define CCC_MODE_LO 0
`define CCC_TBSEL_BIT 3
`define CCC_FLAG_BIT 0

`define CCC_CONTROL_RST 8'h00
`define CCC_TIMER3_RST 8'h00
`define CCC_TIMER3_WMASK 8'hBF
`define CCC_CAP_RST 16'h0000

`define CCC_MODE_OFF 4'h0
`define CCC_MODE_TOGGLE 4'h2
`define CCC_MODE_CAP_FALL 4'h4
`define CCC_MODE_CAP_RISE 4'h5
`define CCC_MODE_CAP_4 4'h6
`define CCC_MODE_CAP_16 4'h7
`define CCC_MODE_CMP_SET 4'h8
`define CCC_MODE_CMP_CLR 4'h9
`define CCC_MODE_CMP_SOFT 4'hA
`define CCC_MODE_CMP_SPECIAL 4'hB
`define CCC_MODE_PWM_TOP 2'h3

`define CCC_PRE4_LAST 4'h3
`define CCC_PRE16_LAST 4'hF

`define CCC_CFG_SINGLE 2'h0
`define CCC_CFG_FORWARD 2'h1
`define CCC_CFG_HALF 2'h2
`define CCC_CFG_REVERSE 2'h3

`endif

/* hdl/ccc_pkg.sv */
// Types shared by the capture/compare unit and its surroundings
package ccc_pkg;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } ccc_quad_type;

   typedef struct packed {
      logic [15:0] first;
      logic [15:0] second;
   } ccc_counts_type;

   typedef struct packed {
      logic first_reset;
      logic second_reset;
      logic adc_start;
   } ccc_trig_type;

endpackage

/* hdl/ccc_unit.sv */
// Capture/compare control unit with APB register access
//
// Summary of operation
// - Special event resets second timer when selected
// - Special event starts conversion only if enabled
// - Software timer write beats special reset
// - Non-PWM modes leave outputs B, C, D free
// - PWM output configuration picks bridge arrangement
// - Duty value is capture low byte plus bits
// - Mode zero switches off and resets unit
// - Capture edge by mode, prescale four, sixteen
// - Compare toggle, set or clear pin, flag
// - Software interrupt mode only raises flag
// - Special event resets timer, conversion, flag
// - PWM mode bits set output polarity
// - Timebase bit picks first or second timer
// - Capture copies selected sixteen-bit count
// - Capture sets flag; software clears it
// - New capture overwrites unread old value
// - Edge detector watches pin even when driven
// - Prescaler cleared when off or leaving capture
// - Prescaler kept across prescale setting changes
//
// Chosen here: the APB register port and the register addresses.
`include "ccc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ccc_unit (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`CCC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer and converter side
   input wire ccc_pkg::ccc_counts_type timer_counts,
   input wire logic second_timer_write,
   input wire logic adc_enabled,
   output ccc_pkg::ccc_trig_type trigger,
   output logic [7:0] timer3_control,
   // Pin side and PWM source
   input wire logic unit_pin_in,
   input wire logic pwm_modulated,
   input wire logic pwm_complement,
   output ccc_pkg::ccc_quad_type output_level,
   output ccc_pkg::ccc_quad_type output_drive,
   output logic [9:0] duty_value,
   output logic unit_event_flag
);
   import ccc_pkg::*;

   function automatic logic is_capture(input logic [3:0] m);
      is_capture = (m >= `CCC_MODE_CAP_FALL) && (m <= `CCC_MODE_CAP_16);
   endfunction
   function automatic logic is_compare(input logic [3:0] m);
      is_compare = (m == `CCC_MODE_TOGGLE) ||
                   ((m >= `CCC_MODE_CMP_SET) && (m <= `CCC_MODE_CMP_SPECIAL));
   endfunction
   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = (m[3:2] == `CCC_MODE_PWM_TOP);
   endfunction
   // Register state
   logic [7:0] unit_control;
   logic [15:0] capture_value_pair;
   logic [31:0] next_prdata;
   // Capture path state
   logic sync_meta;
   logic sync_level;
   logic level_prev;
   logic [3:0] presc_count;
   logic [3:0] next_presc_count;
   // Compare path state
   logic match_prev;
   logic cmp_out;
   logic next_cmp_out;
   logic [3:0] mode_prev;
   // Control fields
   wire [3:0] unit_mode_select = unit_control[`CCC_MODE_HI:`CCC_MODE_LO];
   wire [1:0] output_config_select = unit_control[`CCC_CFG_HI:`CCC_CFG_LO];
   wire [1:0] duty_low_bits = unit_control[`CCC_DUTY_HI:`CCC_DUTY_LO];
   wire timebase_select_bit = timer3_control[`CCC_TBSEL_BIT];

   // APB decode
   wire apb_phase = psel & penable;
   wire apb_done = apb_phase & pready;
   wire apb_write = apb_done & pwrite;
   wire hit_control = (paddr == `CCC_OFS_CONTROL);
   wire hit_timer3 = (paddr == `CCC_OFS_TIMER3);
   wire hit_cap_low = (paddr == `CCC_OFS_CAP_LOW);
   wire hit_cap_high = (paddr == `CCC_OFS_CAP_HIGH);
   wire hit_status = (paddr == `CCC_OFS_STATUS);
   wire addr_hit = hit_control | hit_timer3 | hit_cap_low | hit_cap_high | hit_status;
   wire wr_control = apb_write & hit_control;
   wire wr_timer3 = apb_write & hit_timer3;
   wire wr_cap_low = apb_write & hit_cap_low;
   wire wr_cap_high = apb_write & hit_cap_high;
   wire flag_clear = apb_write & hit_status & pwdata[`CCC_FLAG_BIT];
   wire [31:0] read_word =
      hit_control  ? {24'h000000, unit_control} :
      hit_timer3   ? {24'h000000, timer3_control} :
      hit_cap_low  ? {24'h000000, capture_value_pair[7:0]} :
      hit_cap_high ? {24'h000000, capture_value_pair[15:8]} :
      hit_status   ? {31'h00000000, unit_event_flag} : 32'h00000000;
   // Answer one cycle into the access phase; data sampled then
   always_comb begin
      next_prdata = prdata;
      if (apb_phase && !pready) begin
         next_prdata = read_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apb_phase & ~pready;
         pslverr <= apb_phase & ~pready & ~addr_hit;
         prdata <= next_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_control <= `CCC_CONTROL_RST;
         timer3_control <= `CCC_TIMER3_RST;
      end else begin
         if (wr_control) begin
            unit_control <= pwdata[7:0];
         end
         if (wr_timer3) begin
            timer3_control <= pwdata[7:0] & `CCC_TIMER3_WMASK;
         end
      end
   end

   wire [15:0] sel_count = timebase_select_bit ? timer_counts.second : timer_counts.first;
   // two-stage synchroniser, edges from the second stage onward
   // pin level sampled regardless of who drives it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_meta <= 1'b0;
         sync_level <= 1'b0;
         level_prev <= 1'b0;
      end else begin
         sync_meta <= unit_pin_in;
         sync_level <= sync_meta;
         level_prev <= sync_level;
      end
   end
   wire pin_rise = sync_level & ~level_prev;
   wire pin_fall = ~sync_level & level_prev;
   wire in_capture = is_capture(unit_mode_select);
   wire mode_pre4 = (unit_mode_select == `CCC_MODE_CAP_4);
   wire mode_pre16 = (unit_mode_select == `CCC_MODE_CAP_16);
   wire presc_active = mode_pre4 | mode_pre16;
   // count kept on a prescale change, so a reached limit fires early
   wire presc_hit4 = mode_pre4 & (presc_count >= `CCC_PRE4_LAST);
   wire presc_hit16 = mode_pre16 & (presc_count >= `CCC_PRE16_LAST);
   wire capture_event =
      ((unit_mode_select == `CCC_MODE_CAP_FALL) & pin_fall) |
      ((unit_mode_select == `CCC_MODE_CAP_RISE) & pin_rise) |
      (pin_rise & (presc_hit4 | presc_hit16));

   always_comb begin
      next_presc_count = presc_count;
      if (!in_capture) begin
         next_presc_count = 4'h0;
      end else if (presc_active && pin_rise) begin
         if (presc_hit4 || presc_hit16) begin
            next_presc_count = 4'h0;
         end else begin
            next_presc_count = presc_count + 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_count <= 4'h0;
      end else begin
         presc_count <= next_presc_count;
      end
   end

   // copy count on capture; no overrun guard, capture beats a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_value_pair <= `CCC_CAP_RST;
      end else if (capture_event) begin
         capture_value_pair <= sel_count;
      end else begin
         if (wr_cap_low) begin
            capture_value_pair[7:0] <= pwdata[7:0];
         end
         if (wr_cap_high) begin
            capture_value_pair[15:8] <= pwdata[7:0];
         end
      end
   end

   // Compare: one event per entry into a match, not every cycle it lasts
   wire match_now = is_compare(unit_mode_select) & (capture_value_pair == sel_count);
   wire match_event = match_now & ~match_prev;
   wire special_event = match_event & (unit_mode_select == `CCC_MODE_CMP_SPECIAL);
   wire mode_changed = (unit_mode_select != mode_prev);
   always_comb begin
      next_cmp_out = cmp_out;
      if (unit_mode_select == `CCC_MODE_OFF) begin
         next_cmp_out = 1'b0;
      end else if (mode_changed && unit_mode_select == `CCC_MODE_CMP_SET) begin
         next_cmp_out = 1'b0;
      end else if (mode_changed && unit_mode_select == `CCC_MODE_CMP_CLR) begin
         next_cmp_out = 1'b1;
      end else if (match_event) begin
         case (unit_mode_select)
            `CCC_MODE_TOGGLE: next_cmp_out = ~cmp_out;
            `CCC_MODE_CMP_SET: next_cmp_out = 1'b1;
            `CCC_MODE_CMP_CLR: next_cmp_out = 1'b0;
            default: next_cmp_out = cmp_out;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_prev <= 1'b0;
         cmp_out <= 1'b0;
         mode_prev <= `CCC_MODE_OFF;
      end else begin
         match_prev <= match_now;
         cmp_out <= next_cmp_out;
         mode_prev <= unit_mode_select;
      end
   end

   // sticky flag, set wins over a same-cycle clear
   // every compare match, software mode included, raises it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_event_flag <= 1'b0;
      end else begin
         unit_event_flag <= capture_event | match_event | (unit_event_flag & ~flag_clear);
      end
   end

   // reset goes to whichever timer is the time base
   // a coinciding second timer write suppresses the second timer reset
   // conversion only with the converter enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger <= '0;
      end else begin
         trigger.first_reset <= special_event & ~timebase_select_bit;
         trigger.second_reset <= special_event & timebase_select_bit & ~second_timer_write;
         trigger.adc_start <= special_event & adc_enabled;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_value <= 10'h000;
      end else begin
         duty_value <= {capture_value_pair[7:0], duty_low_bits};
      end
   end
   // Output steering
   wire in_pwm = is_pwm(unit_mode_select);
   wire pol_ac = unit_mode_select[1];
   wire pol_bd = unit_mode_select[0];
   wire cmp_drives_pin = (unit_mode_select == `CCC_MODE_TOGGLE) ||
                         (unit_mode_select == `CCC_MODE_CMP_SET) ||
                         (unit_mode_select == `CCC_MODE_CMP_CLR);
   ccc_quad_type raw_level;
   ccc_quad_type raw_drive;
   ccc_quad_type next_level;
   ccc_quad_type next_drive;

   // bridge arrangement; steering and dead band live outside
   always_comb begin
      raw_level = '0;
      raw_drive = '0;
      case (output_config_select)
         `CCC_CFG_SINGLE: begin
            raw_level = {4{pwm_modulated}};
            raw_drive = 4'hF;
         end
         `CCC_CFG_FORWARD: begin
            raw_level.a = 1'b1;
            raw_level.d = pwm_modulated;
            raw_drive = 4'hF;
         end
         `CCC_CFG_HALF: begin
            raw_level.a = pwm_modulated;
            raw_level.b = pwm_complement;
            raw_drive.a = 1'b1;
            raw_drive.b = 1'b1;
         end
         `CCC_CFG_REVERSE: begin
            raw_level.b = pwm_modulated;
            raw_level.c = 1'b1;
            raw_drive = 4'hF;
         end
         default: raw_drive = '0;
      endcase
   end

   // polarity per pair; config ignored outside PWM
   always_comb begin
      next_level = '0;
      next_drive = '0;
      if (in_pwm) begin
         next_level = raw_level ^ {pol_ac, pol_bd, pol_ac, pol_bd};
         next_drive = raw_drive;
      end else if (cmp_drives_pin) begin
         next_level.a = cmp_out;
         next_drive.a = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_level <= '0;
         output_drive <= '0;
      end else begin
         output_level <= next_level;
         output_drive <= next_drive;
      end
   end

   // Checks
   default clocking ccc_cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_special_first: assert property (special_event && !timebase_select_bit |=>
      trigger.first_reset && !trigger.second_reset)
      else $error("special event did not reset first timer");
   a_adc_gate: assert property (trigger.adc_start |->
      $past(adc_enabled) && $past(special_event))
      else $error("conversion started without enabled converter");
   a_write_wins: assert property (special_event && timebase_select_bit && second_timer_write
      |=> !trigger.second_reset)
      else $error("timer reset beat a software write");
   a_port_free: assert property (!in_pwm |=>
      !output_drive.b && !output_drive.c && !output_drive.d)
      else $error("outputs b c d driven outside pwm");
   a_forward_map: assert property (in_pwm && output_config_select == `CCC_CFG_FORWARD |=>
      output_drive == 4'hF && output_level.d == ($past(pwm_modulated) ^ $past(pol_bd)))
      else $error("forward bridge mapping wrong");
   a_duty_join: assert property (wr_control |=> ##1
      duty_value[1:0] == $past(pwdata[`CCC_DUTY_HI:`CCC_DUTY_LO], 2))
      else $error("duty low bits not taken");
   a_off_clear: assert property (unit_mode_select == `CCC_MODE_OFF |=>
      presc_count == 4'h0 && cmp_out == 1'b0)
      else $error("off mode left state");
   a_quarter_rate: assert property (pin_rise && mode_pre4 && presc_count < `CCC_PRE4_LAST
      |-> !capture_event)
      else $error("prescale four fired early");
   a_set_on_match: assert property (match_event && unit_mode_select == `CCC_MODE_CMP_SET
      && !mode_changed |=> cmp_out && unit_event_flag)
      else $error("set-on-match failed");
   a_soft_pin: assert property (unit_mode_select == `CCC_MODE_CMP_SOFT |=>
      !output_drive.a)
      else $error("software mode drove the pin");
   a_capture_copy: assert property (capture_event |=>
      capture_value_pair == $past(sel_count) && unit_event_flag)
      else $error("capture value or flag wrong");
   a_flag_sticky: assert property (unit_event_flag && !flag_clear |=> unit_event_flag)
      else $error("flag cleared by hardware");
   a_leave_capture: assert property (in_capture ##1 !in_capture |=> presc_count == 4'h0)
      else $error("prescaler kept after capture left");
   a_sync_depth: assert property (pin_rise |->
      $past(unit_pin_in, 2) && !$past(unit_pin_in, 3))
      else $error("edge not from synchronised samples");
   c_capture: cover property (capture_event ##1 unit_event_flag);
   c_special: cover property (special_event && timebase_select_bit);
   c_clash: cover property (special_event && second_timer_write);
   c_reverse: cover property (in_pwm && output_config_select == `CCC_CFG_REVERSE);

endmodule

`default_nettype wire

/* verification/ccc_far_model.sv */
// Far-side model: the two wide timers and the unit pin pad
`timescale 1ns/1ns
`default_nettype none

module ccc_far_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench control
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic pin_req,
   // Unit side
   input wire ccc_pkg::ccc_trig_type trigger,
   output ccc_pkg::ccc_counts_type timer_counts,
   output logic unit_pin_in
);
   import ccc_pkg::*;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_counts <= '0;
      end else if (load) begin
         timer_counts <= {load_value, ~load_value};
      end else begin
         timer_counts.first <= trigger.first_reset ? 16'h0000 : timer_counts.first + 16'(run);
         timer_counts.second <= trigger.second_reset ? 16'h0000 : timer_counts.second + 16'(run);
      end
   end

   // Pad level, also when driven
   assign unit_pin_in = pin_req;
endmodule

`default_nettype wire

/* verification/test_capture_compare_control.sv */
// Self-checking bench for the capture/compare unit
`include "ccc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module test_capture_compare_control;
   import ccc_pkg::*;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
      logic err;
   } ccc_row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ccc_counts_type counts;
   ccc_trig_type trigger;
   ccc_quad_type level;
   ccc_quad_type drive;
   logic tw = 1'b0;
   logic adc = 1'b0;
   logic pin = 1'b0;
   logic pm = 1'b1;
   logic pc = 1'b0;
   logic run = 1'b0;
   logic [15:0] load_value = 16'h0000;
   logic [7:0] t3_copy;
   logic [9:0] duty;
   logic flag;
   logic pin_in;
   logic [31:0] rd;
   logic err;
   logic [7:0] lv;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_sec = 0;
   int n_first = 0;
   int n_adc = 0;
   ccc_row_type rows [5];
   logic [3:0] cmp_mode [4] = '{4'h8, 4'h9, 4'hA, 4'h2};
   logic [1:0] cmp_init [4] = '{2'h2, 2'h3, 2'h0, 2'h2};
   logic [1:0] cmp_after [4] = '{2'h3, 2'h2, 2'h0, 2'h3};

   ccc_unit dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_counts(counts), .second_timer_write(tw), .adc_enabled(adc), .trigger(trigger),
      .timer3_control(t3_copy), .unit_pin_in(pin_in), .pwm_modulated(pm),
      .pwm_complement(pc), .output_level(level), .output_drive(drive), .duty_value(duty),
      .unit_event_flag(flag)
   );

   ccc_far_model far (
      .pclk(pclk), .presetn(presetn), .run(run), .load(tw), .load_value(load_value),
      .pin_req(pin), .trigger(trigger), .timer_counts(counts), .unit_pin_in(pin_in)
   );

   always #5 pclk = ~pclk;

   // Trigger pulse tally and hang guard
   always @(posedge pclk) begin
      n_sec += (trigger.second_reset === 1'b1);
      n_first += (trigger.first_reset === 1'b1);
      n_adc += (trigger.adc_start === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   // Timer load, held h cycles on the write strobe
   task automatic set_t(input logic [15:0] v, input int h);
      load_value <= v;
      tw <= 1'b1;
      cyc(h);
      tw <= 1'b0;
      cyc(1);
   endtask

   task automatic edge_to(input logic v);
      pin <= v;
      cyc(6);
   endtask

   task automatic rises(input int n);
      repeat (n) begin
         edge_to(1'b0);
         edge_to(1'b1);
      end
   endtask

   // Expected {level, drive}: modulated m, complement ~m, polarity p
   function automatic logic [7:0] pwm_exp(input logic [1:0] c, input logic [1:0] p,
      input logic m);
      logic [3:0] l;
      case (c)
         2'h0: l = {4{m}};
         2'h1: l = {1'h1, 2'h0, m};
         2'h2: l = {m, ~m, 2'h0};
         default: l = {1'h0, m, 1'h1, 1'h0};
      endcase
      l = l ^ {p[1], p[0], p[1], p[0]};
      return {l, (c == 2'h2) ? 4'hC : 4'hF};
   endfunction

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      rows = '{'{12'h008, 8'h34, 8'h34, 1'b0}, '{12'h00C, 8'h12, 8'h12, 1'b0},
               '{12'h004, 8'hFF, 8'hBF, 1'b0}, '{12'h000, 8'hA5, 8'hA5, 1'b0},
               '{12'h020, 8'h55, 8'h00, 1'b1}};
      cyc(20);
      presetn <= 1'b1;
      cyc(1);
      check("reset_out", {flag, trigger, drive, level, duty}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 8'h00);
         check("reset_reg", rd, 32'h0);
      end
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         apb(1'b0, rows[i].addr, 8'h00);
         check("reg_read", rd, {24'h000000, rows[i].rexp});
         check("reg_err", err, rows[i].err);
      end
      check("duty", duty, 10'h0D2);
      check("t3_copy", t3_copy, 8'hBF);
      for (int i = 0; i < 32; i++) begin
         pm <= ~i[4];
         pc <= i[4];
         wr(`CCC_OFS_CONTROL, {i[3:2], 4'h3, i[1:0]});
         cyc(2);
         lv = pwm_exp(i[3:2], i[1:0], ~i[4]);
         check("pwm_drive", drive, lv[3:0]);
         check("pwm_level", level & lv[3:0], lv[7:4] & lv[3:0]);
      end
      wr(`CCC_OFS_CONTROL, 8'hC5);
      cyc(2);
      check("nonpwm_drive", drive, 4'h0);
      wr(`CCC_OFS_TIMER3, 8'h00);
      set_t(16'h1234, 1);
      edge_to(1'b0);
      wr(`CCC_OFS_STATUS, 8'h01);
      edge_to(1'b1);
      apb(1'b0, `CCC_OFS_CAP_LOW, 8'h00);
      check("cap_low", rd, 32'h34);
      apb(1'b0, `CCC_OFS_CAP_HIGH, 8'h00);
      check("cap_high", rd, 32'h12);
      check("cap_flag", flag, 1'b1);
      wr(`CCC_OFS_STATUS, 8'h01);
      check("flag_clear", flag, 1'b0);
      wr(`CCC_OFS_TIMER3, 8'h08);
      set_t(16'h5678, 1);
      edge_to(1'b0);
      check("rise_only", flag, 1'b0);
      edge_to(1'b1);
      apb(1'b0, `CCC_OFS_CAP_HIGH, 8'h00);
      check("cap_second", rd, 32'hA9);
      wr(`CCC_OFS_CONTROL, 8'h04);
      wr(`CCC_OFS_STATUS, 8'h01);
      edge_to(1'b0);
      check("fall_flag", flag, 1'b1);
      wr(`CCC_OFS_CONTROL, 8'h06);
      wr(`CCC_OFS_STATUS, 8'h01);
      rises(3);
      check("pre4_early", flag, 1'b0);
      rises(1);
      check("pre4_fire", flag, 1'b1);
      wr(`CCC_OFS_STATUS, 8'h01);
      rises(2);
      wr(`CCC_OFS_CONTROL, 8'h00);
      wr(`CCC_OFS_CONTROL, 8'h06);
      wr(`CCC_OFS_STATUS, 8'h01);
      rises(3);
      check("pre_cleared", flag, 1'b0);
      rises(1);
      check("pre_refire", flag, 1'b1);
      wr(`CCC_OFS_STATUS, 8'h01);
      rises(2);
      wr(`CCC_OFS_CONTROL, 8'h07);
      wr(`CCC_OFS_STATUS, 8'h01);
      rises(13);
      check("pre16_early", flag, 1'b0);
      rises(1);
      check("pre16_kept", flag, 1'b1);
      wr(`CCC_OFS_TIMER3, 8'h00);
      wr(`CCC_OFS_CAP_LOW, 8'h20);
      wr(`CCC_OFS_CAP_HIGH, 8'h00);
      for (int i = 0; i < 4; i++) begin
         set_t(16'h0030, 1);
         wr(`CCC_OFS_CONTROL, 8'h00);
         wr(`CCC_OFS_CONTROL, {4'h0, cmp_mode[i]});
         cyc(3);
         wr(`CCC_OFS_STATUS, 8'h01);
         check("cmp_init", {drive.a, drive.a & level.a}, cmp_init[i]);
         set_t(16'h0020, 1);
         cyc(4);
         check("cmp_after", {drive.a, drive.a & level.a}, cmp_after[i]);
         check("cmp_flag", flag, 1'b1);
      end
      wr(`CCC_OFS_TIMER3, 8'h08);
      wr(`CCC_OFS_CAP_LOW, 8'h10);
      adc <= 1'b1;
      set_t(16'hFFF0, 1);
      wr(`CCC_OFS_CONTROL, 8'h0B);
      for (int k = 0; k < 2; k++) begin
         wr(`CCC_OFS_STATUS, 8'h01);
         n_sec = 0;
         n_first = 0;
         n_adc = 0;
         run <= 1'b1;
         cyc(60);
         run <= 1'b0;
         cyc(2);
         check("sec_reset", n_sec > 1, 1'b1);
         check("first_reset", n_first, 0);
         check("adc_start", n_adc, (k == 0) ? n_sec : 0);
         check("sev_flag", flag, 1'b1);
         adc <= 1'b0;
      end
      set_t(16'hFFAF, 1);
      wr(`CCC_OFS_STATUS, 8'h01);
      n_sec = 0;
      set_t(16'hFFEF, 3);
      cyc(4);
      check("write_wins", n_sec, 0);
      check("write_flag", flag, 1'b1);
      // special event on the first timer
      wr(`CCC_OFS_TIMER3, 8'h00);
      set_t(16'h000F, 1);
      n_sec = 0;
      n_first = 0;
      run <= 1'b1;
      cyc(60);
      run <= 1'b0;
      cyc(2);
      check("first_period", n_first > 1, 1'b1);
      check("first_only", n_sec, 0);
      // mid-run reset, pin idle low first
      edge_to(1'b0);
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      check("rerun_out", {flag, trigger, drive, level, duty, t3_copy}, 32'h0);
      apb(1'b0, `CCC_OFS_CONTROL, 8'h00);
      check("rerun_ctrl", rd, 32'h0);
      complete_run();
   end
endmodule

`default_nettype wire
